// file: logic/afe_port_cfg_pkg.sv
package afe_port_cfg_pkg;
  // register byte offsets
  localparam logic [11:0] usb_frontend_upstream_control_off = 12'h0C8;
  localparam logic [11:0] interchip_port_enable_off = 12'h140;
  // front-end control field positions
  localparam int term_enable_bit = 29;
  localparam int squelch_n_bit = 28;
  localparam int disconnect_bit = 27;
  localparam int squelch_tune_lsb = 24;
  localparam int squelch_tune_w = 3;
  // inter-chip enable field positions
  localparam int port_select_bit = 24;
  localparam int impedance_bit = 18;
  localparam int slew_bit = 17;
  localparam int swap_bit = 16;
  // reset values
  localparam logic [2:0] squelch_tune_zero = 3'h0;
  localparam logic term_enable_rst = 1'b0;
  // axi responses
  localparam logic [1:0] resp_okay = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;
endpackage

// file: logic/usb_afe_interchip_port_config.sv
`timescale 1ns/1ns
// Functional notes
// - termination bit connects high-speed line termination
// - squelch flag bit 28, read-only, active low
// - three-bit squelch tune field, bits 26:24
// - tune default: eeprom, else otp, else zero
// - usb or lite reset reloads tune image
// - tune field guarded by reset protection
// - port select bit 24: usb or inter-chip
// - port select resets from strap pin level
// - bit 18 selects data/strobe driver impedance
// - bit 17 applies 30% slew adjustment
// - bit 16 swaps data and strobe pins
// - bits 18:16 default and restore from image
module usb_afe_interchip_port_config
  import afe_port_cfg_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic usb_reset,
  input wire logic lite_reset,
  input wire logic reset_protect,
  input wire logic eeprom_present,
  input wire logic otp_configured,
  input wire logic [2:0] eeprom_squelch_threshold,
  input wire logic [2:0] otp_squelch_threshold,
  input wire logic [2:0] eeprom_ds_flags,
  input wire logic [2:0] otp_ds_flags,
  input wire logic interchip_select_strap,
  input wire logic afe_squelch_n,
  input wire logic afe_disconnect,
  output logic highspeed_termination_enable,
  output logic [2:0] squelch_trip_tune,
  output logic interchip_port_select,
  output logic data_strobe_impedance_select,
  output logic data_strobe_slew_boost,
  output logic data_strobe_swap
);

  // strap pin: two flops before the select logic reads it
  logic strap_meta;
  logic strap_sync;
  always_ff @(posedge aclk) begin
    strap_meta <= interchip_select_strap;
    strap_sync <= strap_meta;
  end

  // squelch status pin: two flops, read back as bit 28
  logic squelch_meta;
  logic highspeed_squelch_n;
  always_ff @(posedge aclk) begin
    squelch_meta <= afe_squelch_n;
    highspeed_squelch_n <= squelch_meta;
  end

  // disconnect status pin: two flops, reported live
  // the consumer strobes it at the end of a high-speed packet
  logic disc_meta;
  logic highspeed_disconnect_flag;
  always_ff @(posedge aclk) begin
    disc_meta <= afe_disconnect;
    highspeed_disconnect_flag <= disc_meta;
  end

  // one-shot load strobe for the first cycle after reset release;
  // a reset of two edges or more lets the strap synchroniser fill first
  logic strap_pending;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      strap_pending <= 1'b1;
    end else begin
      strap_pending <= 1'b0;
    end
  end

  // configuration image selection: eeprom first, otp next, zero last
  // the image inputs are levels that stay put while a reset restores them
  logic [2:0] image_tune;
  logic [2:0] image_ds;
  assign image_tune = eeprom_present ? eeprom_squelch_threshold :
                      otp_configured ? otp_squelch_threshold : squelch_tune_zero;
  assign image_ds = eeprom_present ? eeprom_ds_flags :
                    otp_configured ? otp_ds_flags : 3'h0;

  // usb or lite reset restores the image; protection shields the tune field only
  logic sys_reload;
  logic tune_load;
  logic ds_load;
  assign sys_reload = usb_reset || lite_reset;
  assign tune_load = strap_pending || (sys_reload && !reset_protect);
  assign ds_load = strap_pending || sys_reload;

  // write handshake: each half is held until its partner arrives
  // a response still waiting blocks both channels, so one write is in flight
  logic aw_held;
  logic w_held;
  logic aw_take;
  logic w_take;
  logic b_take;
  logic do_write;
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;
  assign b_take = s_axi_bvalid && s_axi_bready;
  assign do_write = aw_held && w_held && !s_axi_bvalid;

  // write address decode on the word address
  logic [11:0] aw_addr;
  logic [11:0] aw_word;
  logic sel_ctrl_w;
  logic sel_ichip_w;
  logic write_hit;
  assign aw_word = {aw_addr[11:2], 2'b00};
  assign sel_ctrl_w = aw_word == usb_frontend_upstream_control_off;
  assign sel_ichip_w = aw_word == interchip_port_enable_off;
  assign write_hit = sel_ctrl_w || sel_ichip_w;

  // per-field write strobes; lane 3 carries bits 31:24, lane 2 bits 23:16
  // a lane left out of the strobe leaves its fields untouched
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_ctrl_hi;
  logic wr_ichip_hi;
  logic wr_ichip_mid;
  assign wr_ctrl_hi = do_write && sel_ctrl_w && w_strb[3];
  assign wr_ichip_hi = do_write && sel_ichip_w && w_strb[3];
  assign wr_ichip_mid = do_write && sel_ichip_w && w_strb[2];

  // address half of a write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= 12'h000;
    end else if (aw_take) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  // data half of a write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (w_take) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  // write response valid: raised one cycle after both halves are held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
    end else if (b_take) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // write response code: unmapped words answer with an error
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bresp <= resp_okay;
    end else if (do_write) begin
      s_axi_bresp <= write_hit ? resp_okay : resp_slverr;
    end
  end

  // termination enable
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      highspeed_termination_enable <= term_enable_rst;
    end else if (wr_ctrl_hi) begin
      highspeed_termination_enable <= w_data[term_enable_bit];
    end
  end

  // squelch tune: image after reset and on unprotected reload, else software
  // a reload in the same cycle as a write wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      squelch_trip_tune <= squelch_tune_zero;
    end else if (tune_load) begin
      squelch_trip_tune <= image_tune;
    end else if (wr_ctrl_hi) begin
      squelch_trip_tune <= w_data[squelch_tune_lsb +: squelch_tune_w];
    end
  end

  // port select: strap level after reset, software afterwards
  // a usb or lite reset leaves the selected mode alone
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      interchip_port_select <= 1'b0;
    end else if (strap_pending) begin
      interchip_port_select <= strap_sync;
    end else if (wr_ichip_hi) begin
      interchip_port_select <= w_data[port_select_bit];
    end
  end

  // driver impedance, slew boost and pin swap
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      data_strobe_impedance_select <= 1'b0;
      data_strobe_slew_boost <= 1'b0;
      data_strobe_swap <= 1'b0;
    end else if (ds_load) begin
      {data_strobe_impedance_select, data_strobe_slew_boost, data_strobe_swap} <= image_ds;
    end else if (wr_ichip_mid) begin
      data_strobe_impedance_select <= w_data[impedance_bit];
      data_strobe_slew_boost <= w_data[slew_bit];
      data_strobe_swap <= w_data[swap_bit];
    end
  end

  // read address decode and handshake terms
  logic [11:0] ar_word;
  logic sel_ctrl_r;
  logic sel_ichip_r;
  logic read_hit;
  logic ar_take;
  logic r_take;
  assign ar_word = {s_axi_araddr[11:2], 2'b00};
  assign sel_ctrl_r = ar_word == usb_frontend_upstream_control_off;
  assign sel_ichip_r = ar_word == interchip_port_enable_off;
  assign read_hit = sel_ctrl_r || sel_ichip_r;
  assign ar_take = s_axi_arvalid && s_axi_arready;
  assign r_take = s_axi_rvalid && s_axi_rready;

  // read data assembly; reserved bits stay zero
  logic [31:0] ctrl_word;
  logic [31:0] ichip_word;
  always_comb begin
    ctrl_word = 32'h0000_0000;
    ctrl_word[term_enable_bit] = highspeed_termination_enable;
    ctrl_word[squelch_n_bit] = highspeed_squelch_n;
    ctrl_word[disconnect_bit] = highspeed_disconnect_flag;
    ctrl_word[squelch_tune_lsb +: squelch_tune_w] = squelch_trip_tune;
    ichip_word = 32'h0000_0000;
    ichip_word[port_select_bit] = interchip_port_select;
    ichip_word[impedance_bit] = data_strobe_impedance_select;
    ichip_word[slew_bit] = data_strobe_slew_boost;
    ichip_word[swap_bit] = data_strobe_swap;
  end

  // read word and code for the addressed register
  logic [31:0] read_word;
  logic [1:0] read_resp;
  assign read_word = sel_ctrl_r ? ctrl_word : sel_ichip_r ? ichip_word : 32'h0000_0000;
  assign read_resp = read_hit ? resp_okay : resp_slverr;

  // read valid: address taken when no data pending, answer next cycle
  // status bits are captured at that edge and do not follow the pins afterwards
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
    end else if (ar_take) begin
      s_axi_rvalid <= 1'b1;
    end else if (r_take) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // read payload held until the answer is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= resp_okay;
    end else if (ar_take) begin
      s_axi_rdata <= read_word;
      s_axi_rresp <= read_resp;
    end
  end

endmodule // usb_afe_interchip_port_config

// file: verif/usb_afe_interchip_port_config_assertions.sv
`timescale 1ns/1ns
module afe_cfg_checker (
  input wire logic aclk, aresetn, s_axi_bvalid, s_axi_rvalid, s_axi_awvalid, s_axi_wvalid,
  input wire logic usb_reset, lite_reset, reset_protect, eeprom_present, otp_configured,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [2:0] eeprom_squelch_threshold, otp_squelch_threshold, squelch_trip_tune,
  input wire logic [2:0] eeprom_ds_flags, otp_ds_flags,
  input wire logic highspeed_termination_enable, interchip_port_select,
  input wire logic data_strobe_impedance_select, data_strobe_slew_boost, data_strobe_swap
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // cycles since reset release, saturating
  logic [1:0] age;
  always_ff @(posedge aclk) age <= !aresetn ? 2'h0 : (age == 2'h3 ? age : age + 2'h1);
  // image picks and reload strobe
  wire fresh = age != 2'h3;
  wire rst_any = usb_reset | lite_reset;
  wire [2:0] ds = {data_strobe_impedance_select, data_strobe_slew_boost, data_strobe_swap};
  wire [2:0] img_sq = eeprom_present ? eeprom_squelch_threshold :
    (otp_configured ? otp_squelch_threshold : 3'h0);
  wire [2:0] img_ds = eeprom_present ? eeprom_ds_flags : (otp_configured ? otp_ds_flags : 3'h0);
  sequence reload_s;
    rst_any && !reset_protect;
  endsequence
  AST_TERM: assert property ($changed(highspeed_termination_enable) |-> $rose(s_axi_bvalid))
    else $error("termination changed without a write");
  AST_TUNE_WRITE: assert property ($changed(squelch_trip_tune) |->
    $rose(s_axi_bvalid) || $past(rst_any) || fresh) else $error("tune changed unexpectedly");
  AST_TUNE_RELOAD: assert property (reload_s |=> squelch_trip_tune == $past(img_sq))
    else $error("tune not reloaded from image");
  AST_TUNE_PROTECT: assert property (rst_any && reset_protect && !fresh &&
    !s_axi_awvalid && !s_axi_wvalid |=> $stable(squelch_trip_tune)) else $error("tune not held");
  AST_SEL: assert property ($changed(interchip_port_select) |-> $rose(s_axi_bvalid) || fresh)
    else $error("port select changed without a write");
  AST_DS_CHANGE: assert property ($changed(ds) |->
    $rose(s_axi_bvalid) || $past(rst_any) || fresh) else $error("driver bits changed");
  AST_DS_RELOAD: assert property (rst_any |=> ds == $past(img_ds))
    else $error("driver bits not reloaded");
  AST_RD_RSVD: assert property (s_axi_rvalid |-> (s_axi_rdata & 32'hC0F8_FFFF) == 32'h0)
    else $error("reserved bits read nonzero");
endmodule // afe_cfg_checker
bind usb_afe_interchip_port_config afe_cfg_checker chk (.*);

// file: verif/test_usb_afe_interchip_port_config.sv
`timescale 1ns/1ns
module test_usb_afe_interchip_port_config;
  import afe_port_cfg_pkg::*;
  logic aclk = '0, aresetn = '0, s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_arvalid = '0;
  logic s_axi_bready = 1'h1, s_axi_rready = 1'h1, usb_reset = '0, lite_reset = '0;
  logic reset_protect = '0, eeprom_present = 1'h1, otp_configured = '0;
  logic interchip_select_strap = 1'h1, afe_squelch_n = 1'h1, afe_disconnect = '0;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [2:0] eeprom_squelch_threshold = 3'h5, eeprom_ds_flags = 3'h5;
  logic [2:0] otp_squelch_threshold = '0, otp_ds_flags = '0, squelch_trip_tune;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr, rb;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic highspeed_termination_enable, interchip_port_select;
  logic data_strobe_impedance_select, data_strobe_slew_boost, data_strobe_swap;
  int miscompares = 0, tests_run = 0;
  // all configuration outputs in one word
  wire [7:0] outs = {highspeed_termination_enable, squelch_trip_tune, interchip_port_select,
    data_strobe_impedance_select, data_strobe_slew_boost, data_strobe_swap};
  always #20 aclk = ~aclk;
  usb_afe_interchip_port_config dut (.*);
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // write: both channels offered together, each released once taken
  task wr(input logic [11:0] a, input logic [31:0] d);
    logic pa, pw, ta, tw;
    pa = 1'h1;
    pw = 1'h1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    while (pa | pw) begin
      @(negedge aclk);
      ta = pa & s_axi_awready;
      tw = pw & s_axi_wready;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'h0;
      if (tw) s_axi_wvalid <= 1'h0;
      pa = pa & !ta;
      pw = pw & !tw;
    end
    @(negedge aclk);
    while (!s_axi_bvalid) @(negedge aclk);
    rb = s_axi_bresp;
    @(posedge aclk);
  endtask
  task rd_reg(input logic [11:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    @(negedge aclk);
    while (!s_axi_arready) @(negedge aclk);
    @(posedge aclk);
    s_axi_arvalid <= 1'h0;
    @(negedge aclk);
    while (!s_axi_rvalid) @(negedge aclk);
    rd = s_axi_rdata;
    rr = s_axi_rresp;
    @(posedge aclk);
  endtask
  task t_defaults;
    rd_reg(usb_frontend_upstream_control_off);
    chk(rd, 32'h1500_0000);
    rd_reg(interchip_port_enable_off);
    chk(rd, 32'h0105_0000);
  endtask
  task t_write;
    wr(usb_frontend_upstream_control_off, 32'hFFFF_FFFF);
    wr(interchip_port_enable_off, 32'hFFFF_FFFF);
    chk(32'(outs), 32'h0000_00FF);
    afe_squelch_n <= 1'h0;
    afe_disconnect <= 1'h1;
    repeat (3) @(posedge aclk);
    rd_reg(usb_frontend_upstream_control_off);
    chk(rd, 32'h2F00_0000);
    rd_reg(interchip_port_enable_off);
    chk(rd, 32'h0107_0000);
    rd_reg(12'h004);
    chk(32'(rr) << 8 | rd, 32'(resp_slverr) << 8);
    wr(12'h004, 32'hFFFF_FFFF);
    chk(32'(rb) << 8 | 32'(outs), 32'(resp_slverr) << 8 | 32'h0000_00FF);
    s_axi_wstrb <= 4'h4;
    wr(interchip_port_enable_off, 32'h0000_0000);
    s_axi_wstrb <= 4'hF;
    chk(32'(rb) << 8 | 32'(outs), 32'h0000_00F8);
  endtask
  // reload from otp, then protected reload with no image
  task t_reload;
    eeprom_present <= 1'h0;
    otp_configured <= 1'h1;
    otp_squelch_threshold <= 3'h3;
    otp_ds_flags <= 3'h2;
    usb_reset <= 1'h1;
    repeat (2) @(posedge aclk);
    usb_reset <= 1'h0;
    @(posedge aclk);
    chk(32'(outs), 32'h0000_00BA);
    otp_configured <= 1'h0;
    reset_protect <= 1'h1;
    lite_reset <= 1'h1;
    repeat (2) @(posedge aclk);
    lite_reset <= 1'h0;
    @(posedge aclk);
    chk(32'(outs), 32'h0000_00B8);
  endtask
  task final_report;
    $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (2) @(posedge aclk);
    t_defaults;
    t_write;
    t_reload;
    final_report;
  end
  // watchdog
  initial begin
    repeat (2000) @(posedge aclk);
    miscompares++;
    final_report;
  end
endmodule // test_usb_afe_interchip_port_config
